/* File: rtl/ssc_pkg.sv */
// Shared constants for the serial synthesizer configuration link.
package ssc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_HALF_NS = 40;
	localparam int HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
	localparam int WORD_BITS = 32;
	localparam logic [4:0] BIT_LAST = 5'd31;

	// ----------------------------------------------------------------
	// Select codes in bits 2:0
	// ----------------------------------------------------------------
	localparam int NUM_LATCH = 5;
	localparam logic [2:0] SEL_INT_FRAC = 3'h0;
	localparam logic [2:0] SEL_PHASE = 3'h1;
	localparam logic [2:0] SEL_MOD_REF = 3'h2;
	localparam logic [2:0] SEL_FUNCTION = 3'h3;
	localparam logic [2:0] SEL_CLKDIV = 3'h4;

	// ----------------------------------------------------------------
	// Field positions (lsb) of the configuration words
	// ----------------------------------------------------------------
	localparam int POS_MON_SEL = 27;
	localparam int POS_INT = 15;
	localparam int POS_FRAC = 3;
	localparam int POS_PHASE = 3;
	localparam int POS_NOISE = 29;
	localparam int POS_SLIP = 28;
	localparam int POS_PUMP = 24;
	localparam int POS_PRESC = 22;
	localparam int POS_HALVER = 21;
	localparam int POS_DOUBLER = 20;
	localparam int POS_REFDIV = 15;
	localparam int POS_MOD = 3;

	// Bits that may be nonzero; all others are reserved and sent as 0.
	localparam logic [31:0] MASK_R0 = 32'h7FFF_FFFF;
	localparam logic [31:0] MASK_R1 = 32'h0000_7FFF;
	localparam logic [31:0] MASK_R2 = 32'h7F7F_FFFF;

	// ----------------------------------------------------------------
	// Legal ranges
	// ----------------------------------------------------------------
	localparam logic [11:0] INT_MIN_P45 = 12'd23;
	localparam logic [11:0] INT_MIN_P89 = 12'd75;
	localparam logic [11:0] MOD_MIN = 12'd2;
	localparam logic [11:0] MOD_RESET = 12'hFFF;
	localparam logic [5:0] REFDIV_ZERO_RATIO = 6'd32;

	// ----------------------------------------------------------------
	// Controller register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_WORD = 12'h000;
	localparam logic [11:0] OFS_CTRL = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam int CTRL_GO = 0;
	localparam int CTRL_AUTO = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_ERR = 1;
	localparam int STAT_DUE = 2;

endpackage

/* File: rtl/ssc_if.sv */
// Three-wire configuration link between controller and synthesizer.
`timescale 1ns/100ps
`default_nettype none
interface ssc_if;
	logic sclk;
	logic sdata;
	logic load_strobe;

	modport host (output sclk, output sdata, output load_strobe);
	modport dev (input sclk, input sdata, input load_strobe);
endinterface
`default_nettype wire

/* File: rtl/ssc_dev.sv */
// Synthesizer end: serial shift register, latch decode, double buffers.
//
// Functional notes
// - Shift data in on serial clock rise.
// - Host sends words most significant bit first.
// - Load strobe rise copies word into latch.
// - Low three bits pick the latch.
// - Codes zero through four map registers.
// - Buffered settings apply on register zero write.
// - Host rewrites register zero after buffered change.
// - Counter widths five and twelve bits.
// - Register zero field layout.
// - Register two field layout.
// - Host keeps integer within 23 to 4095.
// - Host keeps reference ratio 1 to 32.
// - Host keeps modulus within 2 to 4095.
// - Host keeps fraction below modulus.
// - Division is integer plus fraction over modulus.
// - Comparison rate from doubler, divider, halver.
// - Register one holds twelve-bit phase word.
// - Host picks prescaler; minimum 23 or 75.
`timescale 1ns/100ps
`default_nettype none
module ssc_dev
	import ssc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	ssc_if.dev link,
	output logic [3:0] monitor_output_select,
	output logic [11:0] cfg_int,
	output logic [11:0] cfg_frac,
	output logic [11:0] cfg_phase,
	output logic [11:0] fractional_modulus,
	output logic [4:0] reference_divider_value,
	output logic reference_doubler_enable,
	output logic reference_halver_enable,
	output logic [3:0] pump_current_setting,
	output logic [1:0] noise_spur_select,
	output logic slip_reduction_enable,
	output logic prescaler_select,
	output logic [28:0] cfg_function_word,
	output logic [28:0] cfg_clkdiv_word,
	output logic [1:0] pfd_mult,
	output logic [6:0] pfd_div,
	output logic [4:0] latch_written
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// The link pins are asynchronous to pclk; each passes two flops.
	// A third flop on clock and strobe gives the edge detectors an
	// older sample without touching the first stage.
	logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
	logic data_s1_ff, data_s2_ff;
	logic le_s1_ff, le_s2_ff, le_s3_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_s1_ff <= 1'b0;
			sclk_s2_ff <= 1'b0;
			sclk_s3_ff <= 1'b0;
			data_s1_ff <= 1'b0;
			data_s2_ff <= 1'b0;
			le_s1_ff <= 1'b0;
			le_s2_ff <= 1'b0;
			le_s3_ff <= 1'b0;
		end else begin
			sclk_s1_ff <= link.sclk;
			sclk_s2_ff <= sclk_s1_ff;
			sclk_s3_ff <= sclk_s2_ff;
			data_s1_ff <= link.sdata;
			data_s2_ff <= data_s1_ff;
			le_s1_ff <= link.load_strobe;
			le_s2_ff <= le_s1_ff;
			le_s3_ff <= le_s2_ff;
		end
	end

	wire sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
	wire le_rise = le_s2_ff & ~le_s3_ff;

	// ----------------------------------------------------------------
	// Shift register
	// ----------------------------------------------------------------
	// Data and clock share the same synchroniser depth, so the data
	// sample seen with the detected rise is the one present at the pin.
	logic [31:0] shift_ff;
	wire [31:0] nxt_shift = {shift_ff[30:0], data_s2_ff};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			shift_ff <= 32'h0000_0000;
		else if (sclk_rise)
			shift_ff <= nxt_shift;
	end

	// ----------------------------------------------------------------
	// Latch decode
	// ----------------------------------------------------------------
	wire [2:0] sel = shift_ff[2:0];
	logic [4:0] hit;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_LATCH; gi = gi + 1) begin : g_hit
			// Codes above four match no latch and are dropped.
			assign hit[gi] = le_rise && (sel == 3'(gi));
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			latch_written <= 5'h00;
		else
			latch_written <= hit;
	end

	// ----------------------------------------------------------------
	// Register zero: applied at once
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			monitor_output_select <= 4'h0;
			cfg_int <= 12'h000;
			cfg_frac <= 12'h000;
		end else if (hit[SEL_INT_FRAC]) begin
			monitor_output_select <= shift_ff[POS_MON_SEL +: 4];
			cfg_int <= shift_ff[POS_INT +: 12];
			cfg_frac <= shift_ff[POS_FRAC +: 12];
		end
	end

	// ----------------------------------------------------------------
	// Register one and two: pending copies and unbuffered fields
	// ----------------------------------------------------------------
	logic [11:0] pend_phase_ff;
	logic [11:0] pend_mod_ff;
	logic [4:0] pend_ref_ff;
	logic pend_dbl_ff;
	logic pend_half_ff;
	logic [3:0] pend_pump_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pend_phase_ff <= 12'h000;
		else if (hit[SEL_PHASE])
			pend_phase_ff <= shift_ff[POS_PHASE +: 12];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_mod_ff <= 12'h000;
			pend_ref_ff <= 5'h00;
			pend_dbl_ff <= 1'b0;
			pend_half_ff <= 1'b0;
			pend_pump_ff <= 4'h0;
		end else if (hit[SEL_MOD_REF]) begin
			pend_mod_ff <= shift_ff[POS_MOD +: 12];
			pend_ref_ff <= shift_ff[POS_REFDIV +: 5];
			pend_dbl_ff <= shift_ff[POS_DOUBLER];
			pend_half_ff <= shift_ff[POS_HALVER];
			pend_pump_ff <= shift_ff[POS_PUMP +: 4];
		end
	end

	// Noise mode, slip reduction and prescaler are not buffered.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			noise_spur_select <= 2'h0;
			slip_reduction_enable <= 1'b0;
			prescaler_select <= 1'b0;
		end else if (hit[SEL_MOD_REF]) begin
			noise_spur_select <= shift_ff[POS_NOISE +: 2];
			slip_reduction_enable <= shift_ff[POS_SLIP];
			prescaler_select <= shift_ff[POS_PRESC];
		end
	end

	// ----------------------------------------------------------------
	// Active copies, taken over by the next register zero write
	// ----------------------------------------------------------------
	// A register zero write picks up whatever is pending at that
	// moment, so a value written twice before it only the last counts.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_phase <= 12'h000;
			fractional_modulus <= 12'h000;
			reference_divider_value <= 5'h00;
			reference_doubler_enable <= 1'b0;
			reference_halver_enable <= 1'b0;
			pump_current_setting <= 4'h0;
		end else if (hit[SEL_INT_FRAC]) begin
			cfg_phase <= pend_phase_ff;
			fractional_modulus <= pend_mod_ff;
			reference_divider_value <= pend_ref_ff;
			reference_doubler_enable <= pend_dbl_ff;
			reference_halver_enable <= pend_half_ff;
			pump_current_setting <= pend_pump_ff;
		end
	end

	// ----------------------------------------------------------------
	// Function and clock divider words, stored raw
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_function_word <= 29'h0000_0000;
			cfg_clkdiv_word <= 29'h0000_0000;
		end else begin
			if (hit[SEL_FUNCTION])
				cfg_function_word <= shift_ff[31:3];
			if (hit[SEL_CLKDIV])
				cfg_clkdiv_word <= shift_ff[31:3];
		end
	end

	// ----------------------------------------------------------------
	// Comparison rate factors
	// ----------------------------------------------------------------
	// Rate = reference * pfd_mult / pfd_div; the output is that rate
	// times cfg_int + cfg_frac / fractional_modulus, all from the
	// active copies above. A divider code of zero stands for 32.
	wire [5:0] ref_ratio = (reference_divider_value == 5'h00) ?
		REFDIV_ZERO_RATIO : {1'b0, reference_divider_value};
	wire [1:0] nxt_pfd_mult = reference_doubler_enable ? 2'd2 : 2'd1;
	wire [6:0] nxt_pfd_div = reference_halver_enable ?
		{ref_ratio, 1'b0} : {1'b0, ref_ratio};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pfd_mult <= 2'd1;
			pfd_div <= 7'd32;
		end else begin
			pfd_mult <= nxt_pfd_mult;
			pfd_div <= nxt_pfd_div;
		end
	end

endmodule
`default_nettype wire

/* File: rtl/ssc_host.sv */
// Controller end: APB registers, range checks and serial word sender.
`timescale 1ns/100ps
`default_nettype none
module ssc_host
	import ssc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	ssc_if.host link
);

	typedef enum {H_IDLE, H_LOW, H_HIGH, H_STROBE, H_GAP} ssc_hstate_e;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [31:0] word_ff;
	logic auto_ff, err_ff, due_ff, busy;
	wire acc = psel & penable;
	wire hit_word = (paddr == OFS_WORD);
	wire hit_ctrl = (paddr == OFS_CTRL);
	wire hit_stat = (paddr == OFS_STATUS);
	wire mapped = hit_word | hit_ctrl | hit_stat;
	wire wr_word = acc & pwrite & hit_word;
	wire wr_ctrl = acc & pwrite & hit_ctrl;
	wire wr_stat = acc & pwrite & hit_stat;
	wire go = wr_ctrl & pwdata[CTRL_GO] & ~busy;

	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	wire [31:0] stat_word = {29'h0, due_ff, err_ff, busy};
	wire [31:0] rd_mux = hit_word ? word_ff :
		hit_ctrl ? {30'h0, auto_ff, 1'b0} :
		hit_stat ? stat_word : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable)
			prdata <= rd_mux;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_ff <= 32'h0000_0000;
			auto_ff <= 1'b0;
		end else begin
			if (wr_word)
				word_ff <= pwdata;
			if (wr_ctrl)
				auto_ff <= pwdata[CTRL_AUTO];
		end
	end

	// ----------------------------------------------------------------
	// Word checks against the last sent modulus and prescaler
	// ----------------------------------------------------------------
	logic [11:0] sh_mod_ff;
	logic sh_presc_ff;
	logic [31:0] sh_r0_ff;
	logic r0_valid_ff;
	wire [2:0] wsel = word_ff[2:0];
	wire [31:0] mask = (wsel == SEL_INT_FRAC) ? MASK_R0 :
		(wsel == SEL_PHASE) ? MASK_R1 :
		(wsel == SEL_MOD_REF) ? MASK_R2 : 32'hFFFF_FFFF;
	wire [31:0] clean = word_ff & mask;
	wire [11:0] w_int = clean[POS_INT +: 12];
	wire [11:0] w_frac = clean[POS_FRAC +: 12];
	wire [11:0] w_phase = clean[POS_PHASE +: 12];
	wire [11:0] w_mod = clean[POS_MOD +: 12];
	wire [11:0] int_min = sh_presc_ff ? INT_MIN_P89 : INT_MIN_P45;
	wire bad_r0 = (w_int < int_min) | (w_frac >= sh_mod_ff);
	wire bad_r1 = (w_phase >= sh_mod_ff);
	wire bad_r2 = (w_mod < MOD_MIN);
	// Every 5-bit divider code is a legal ratio, zero meaning 32.
	wire bad = (wsel == SEL_INT_FRAC) ? bad_r0 :
		(wsel == SEL_PHASE) ? bad_r1 :
		(wsel == SEL_MOD_REF) ? bad_r2 : (wsel > SEL_CLKDIV);
	wire start = go & ~bad;
	wire buffered = (wsel == SEL_PHASE) | (wsel == SEL_MOD_REF);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_mod_ff <= MOD_RESET;
			sh_presc_ff <= 1'b0;
			sh_r0_ff <= 32'h0000_0000;
			r0_valid_ff <= 1'b0;
		end else if (start) begin
			if (wsel == SEL_MOD_REF) begin
				sh_mod_ff <= w_mod;
				sh_presc_ff <= clean[POS_PRESC];
			end
			if (wsel == SEL_INT_FRAC) begin
				sh_r0_ff <= clean;
				r0_valid_ff <= 1'b1;
			end
		end
	end

	// A refused word sets the error; the set wins over a clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			err_ff <= 1'b0;
		else if (go & bad)
			err_ff <= 1'b1;
		else if (wr_stat & pwdata[STAT_ERR])
			err_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Serial sender
	// ----------------------------------------------------------------
	ssc_hstate_e st_ff;
	logic [31:0] tx_ff;
	logic [3:0] tmr_ff;
	logic [4:0] bit_ff;
	logic commit_ff;
	wire tmr_done = (tmr_ff == HALF_LAST);
	wire finish = (st_ff == H_GAP) & tmr_done;
	wire resend = finish & commit_ff & r0_valid_ff;

	assign busy = (st_ff != H_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= H_IDLE;
			tx_ff <= 32'h0000_0000;
			tmr_ff <= 4'h0;
			bit_ff <= 5'h00;
		end else begin
			tmr_ff <= (st_ff == H_IDLE || tmr_done) ? 4'h0 : tmr_ff + 4'h1;
			case (st_ff)
			H_IDLE: if (start) begin
				tx_ff <= clean;
				bit_ff <= 5'h00;
				st_ff <= H_LOW;
			end
			H_LOW: if (tmr_done)
				st_ff <= H_HIGH;
			H_HIGH: if (tmr_done) begin
				tx_ff <= {tx_ff[30:0], 1'b0};
				bit_ff <= bit_ff + 5'h01;
				st_ff <= (bit_ff == BIT_LAST) ? H_STROBE : H_LOW;
			end
			H_STROBE: if (tmr_done)
				st_ff <= H_GAP;
			H_GAP: if (tmr_done) begin
				if (resend) begin
					tx_ff <= sh_r0_ff;
					bit_ff <= 5'h00;
					st_ff <= H_LOW;
				end else begin
					st_ff <= H_IDLE;
				end
			end
			default: st_ff <= H_IDLE;
			endcase
		end
	end

	// Auto commit is latched per word so a later change of the control
	// bit cannot cut a queued register zero write short.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			commit_ff <= 1'b0;
		else if (start)
			commit_ff <= auto_ff & buffered;
		else if (finish)
			commit_ff <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			due_ff <= 1'b0;
		else if (start & buffered)
			due_ff <= 1'b1;
		else if ((start & (wsel == SEL_INT_FRAC)) | resend)
			due_ff <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.sclk <= 1'b0;
			link.sdata <= 1'b0;
			link.load_strobe <= 1'b0;
		end else begin
			link.sclk <= (st_ff == H_HIGH);
			link.sdata <= tx_ff[31];
			link.load_strobe <= (st_ff == H_STROBE);
		end
	end

endmodule
`default_nettype wire

/* File: bench/ssc_sva.sv */
// Concurrent checks on the three-wire configuration link.
`timescale 1ns/100ps
`default_nettype none
module ssc_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic load_strobe
);
	// ----------------------------------------------------------------
	// Bit counter
	// ----------------------------------------------------------------
	// Counts serial clock rises since the last strobe, so a frame with a
	// missing or extra bit shows up as a wrong count at the next strobe.
	logic sclk_ff;
	logic [5:0] cnt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_ff <= 1'b0;
			cnt_ff <= 6'h00;
		end else begin
			sclk_ff <= sclk;
			if (load_strobe)
				cnt_ff <= 6'h00;
			else if (sclk && !sclk_ff)
				cnt_ff <= cnt_ff + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_data_stable_high: assert property (sclk && $past(sclk) |-> $stable(sdata))
		else $error("serial data moved while serial clock high");
	a_strobe_clk_low: assert property (load_strobe |-> !sclk)
		else $error("serial clock high during strobe");
	a_strobe_width: assert property ($rose(load_strobe) |=> load_strobe[*4] ##1 !load_strobe)
		else $error("strobe width not five cycles");
	a_sclk_high_len: assert property ($rose(sclk) |-> sclk[*5] ##1 !sclk)
		else $error("serial clock high phase not five cycles");
	a_sclk_low_len: assert property ($fell(sclk) |-> !sclk[*5])
		else $error("serial clock low phase too short");
	a_strobe_gap: assert property ($fell(load_strobe) |-> (!load_strobe && !sclk)[*5])
		else $error("link not idle after strobe");
	a_word_bits: assert property ($rose(load_strobe) |-> cnt_ff == 6'h20)
		else $error("strobe not after exactly 32 bits");
	a_bits_bound: assert property (cnt_ff <= 6'h20)
		else $error("more than 32 bits in one word");

	c_word: cover property ($rose(load_strobe));
	c_full: cover property (cnt_ff == 6'h20);
	c_sclk: cover property ($rose(sclk));
endmodule
`default_nettype wire

/* File: bench/synth_serial_config_regs_bench.sv */
// Self-checking bench for the controller and synthesizer link ends.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module synth_serial_config_regs_bench
	import ssc_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rq, mon;
	logic [3:0] mon_sel, c_pump;
	logic [11:0] c_int, c_frac, c_ph, c_mod, x_int;
	logic [4:0] c_rdiv;
	logic c_dbl, c_hlv, c_slip, c_psc;
	logic [1:0] c_ns, p_mult;
	logic [28:0] c_f3, c_f4;
	logic [6:0] p_div;
	logic [4:0] lw, lw_seen;
	logic auto_on = 1'b0;
	int err_total = 0;
	int checks_done = 0;

	ssc_if link();
	ssc_if link2();
	ssc_host ssc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	ssc_dev ssc_dev_i (.pclk(pclk), .presetn(presetn), .link(link),
		.monitor_output_select(mon_sel), .cfg_int(c_int), .cfg_frac(c_frac),
		.cfg_phase(c_ph), .fractional_modulus(c_mod),
		.reference_divider_value(c_rdiv), .reference_doubler_enable(c_dbl),
		.reference_halver_enable(c_hlv), .pump_current_setting(c_pump),
		.noise_spur_select(c_ns), .slip_reduction_enable(c_slip),
		.prescaler_select(c_psc), .cfg_function_word(c_f3),
		.cfg_clkdiv_word(c_f4), .pfd_mult(p_mult), .pfd_div(p_div),
		.latch_written(lw));
	// Second device end, driven by the bench to send codes the host refuses.
	ssc_dev ssc_dev_x_i (.pclk(pclk), .presetn(presetn), .link(link2),
		.monitor_output_select(), .cfg_int(x_int), .cfg_frac(), .cfg_phase(),
		.fractional_modulus(), .reference_divider_value(),
		.reference_doubler_enable(), .reference_halver_enable(),
		.pump_current_setting(), .noise_spur_select(),
		.slip_reduction_enable(), .prescaler_select(), .cfg_function_word(),
		.cfg_clkdiv_word(), .pfd_mult(), .pfd_div(), .latch_written());
	ssc_sva ssc_sva_i (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
		.sdata(link.sdata), .load_strobe(link.load_strobe));

	initial begin
		pclk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
	end

	// The wire monitor rebuilds each word from the serial clock rises.
	always @(posedge link.sclk) mon <= {mon[30:0], link.sdata};

	// The load pulse lasts one cycle, so the last nonzero one is kept.
	always @(posedge pclk) if (lw != 5'h00) lw_seen <= lw;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			end_sim();
		end
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Leaves the final status word in rq.
	task send(input logic [31:0] w);
		int n;
		apb(1'b1, OFS_WORD, w);
		apb(1'b1, OFS_CTRL, {30'h0, auto_on, 1'b1});
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (rq[STAT_BUSY] !== 1'b0 && n < 400);
		if (n >= 400) begin
			err_total++;
			end_sim();
		end
		repeat (3) @(posedge pclk);
	endtask

	task bb(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			link2.sdata <= w[i];
			repeat (5) @(posedge pclk);
			link2.sclk <= 1'b1;
			repeat (5) @(posedge pclk);
			link2.sclk <= 1'b0;
		end
		link2.sdata <= ~w[0];
		link2.load_strobe <= 1'b1;
		repeat (5) @(posedge pclk);
		link2.load_strobe <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask

	task t_reg0;
		logic [31:0] w;
		w = {1'b1, 4'hA, 12'h12C, 12'h005, 3'h0};
		`CHK(p_mult, 2'h1)
		`CHK(p_div, 7'h20)
		send(w);
		`CHK(mon, w & MASK_R0)
		`CHK(mon_sel, 4'hA)
		`CHK(c_int, 12'h12C)
		`CHK(c_frac, 12'h005)
		`CHK(lw_seen, 5'h01)
	endtask

	task t_buffer;
		send({1'b0, 2'h2, 1'b1, 4'h3, 2'h0, 2'h3, 5'h05, 12'h064, 3'h2});
		`CHK(c_ns, 2'h2)
		`CHK(c_slip, 1'b1)
		`CHK(c_mod, 12'h000)
		`CHK(c_pump, 4'h0)
		`CHK(rq[STAT_DUE], 1'b1)
		send({17'h0, 12'h007, 3'h1});
		`CHK(c_ph, 12'h000)
		send({1'b0, 4'h5, 12'h12C, 12'h003, 3'h0});
		`CHK(c_mod, 12'h064)
		`CHK(c_ph, 12'h007)
		`CHK(c_pump, 4'h3)
		`CHK(c_rdiv, 5'h05)
		`CHK({c_dbl, c_hlv}, 2'h3)
		`CHK(p_mult, 2'h2)
		`CHK(p_div, 7'h0A)
		`CHK(rq[STAT_DUE], 1'b0)
	endtask

	task t_refuse;
		send({1'b0, 4'h0, 12'h016, 12'h000, 3'h0});
		`CHK(rq[STAT_ERR], 1'b1)
		`CHK(c_int, 12'h12C)
		apb(1'b1, OFS_STATUS, 32'h0000_0002);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK(rq[STAT_ERR], 1'b0)
		send({29'h0, 3'h5});
		`CHK(rq[STAT_ERR], 1'b1)
		apb(1'b0, 12'h00C, 32'h0);
		`CHK(re, 1'b1)
		`CHK(rq, 32'h0)
	endtask

	task t_reg34;
		send({29'h1234567, 3'h3});
		`CHK(c_f3, 29'h1234567)
		`CHK(lw_seen, 5'h08)
		send({29'h0ABCDEF, 3'h4});
		`CHK(c_f4, 29'h0ABCDEF)
		`CHK(lw_seen, 5'h10)
		`CHK(c_f3, 29'h1234567)
		`CHK(c_int, 12'h12C)
	endtask

	// Auto commit must resend the last register zero word by itself.
	task t_auto;
		apb(1'b1, OFS_STATUS, 32'h0000_0002);
		apb(1'b1, OFS_CTRL, 32'h0000_0002);
		auto_on = 1'b1;
		send({1'b0, 2'h2, 1'b1, 4'h3, 2'h1, 2'h3, 5'h05, 12'h0C8, 3'h2});
		auto_on = 1'b0;
		`CHK(c_psc, 1'b1)
		`CHK(c_mod, 12'h0C8)
		`CHK(mon, {1'b0, 4'h5, 12'h12C, 12'h003, 3'h0})
		`CHK(lw_seen, 5'h01)
		`CHK(rq[STAT_DUE], 1'b0)
		send({1'b0, 4'h0, 12'h032, 12'h000, 3'h0});
		`CHK(rq[STAT_ERR], 1'b1)
		`CHK(c_int, 12'h12C)
	endtask

	task t_dev_ignore;
		bb({5'h00, 12'h028, 12'h001, 3'h0});
		`CHK(x_int, 12'h028)
		for (int c = 5; c < 8; c++) begin
			bb({5'h00, 12'h063, 12'h001, 3'(c)});
			`CHK(x_int, 12'h028)
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		link2.sclk = 1'b0;
		link2.sdata = 1'b0;
		link2.load_strobe = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reg0();
		t_buffer();
		t_refuse();
		t_reg34();
		t_auto();
		t_dev_ignore();
		end_sim();
	end
endmodule
`default_nettype wire
